// ===== hw/spc_pkg.sv
// Contract
// - Power control select clear: control bit 7 is upper mode bit, not framing error.
// - Two mode bits pick shift register, 8-bit UART, 9-bit fixed, 9-bit variable.
// - Multiprocessor enable sorts frames and recognises individual and broadcast addresses.
// - Receiver accepts frames only while receive enable is set; the code checks it only when a frame starts.
// - Modes 2 and 3 send transmit ninth bit; modes 0 and 1 ignore it.
// - Transmit-done set after last data bit sent; stays until software clears.
// - Receive-done set after last data bit received; stays until software clears.
// - Received ninth bit holds stop bit in mode 1, ninth data bit in 2/3.
// - Mode 0 shifts one bit per twelve clocks.
// - Mode 2 bit rate is clock/32 or clock/64.
package spc_pkg;

    // ====================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] ADR_PWR = 8'h08;
    localparam logic [7:0] ADR_SADDR = 8'h0C;
    localparam logic [7:0] ADR_SMASK = 8'h10;
    localparam logic [7:0] ADR_BAUD = 8'h14;
    localparam logic [7:0] ADR_IRQ_ST = 8'h18;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h1C;

    // ====================================================
    // Field positions
    localparam int PWR_FESEL = 6;
    localparam int PWR_DBL = 7;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_FE = 2;

    // ====================================================
    // Reset values and timing counts (sys_clk cycles)
    localparam logic [15:0] BAUD_RST = 16'h01B2;
    localparam logic [15:0] M0_PERIOD = 16'h000C;
    localparam logic [15:0] M0_HALF = 16'h0006;
    localparam logic [15:0] M2_FAST = 16'h0020;
    localparam logic [15:0] M2_SLOW = 16'h0040;
    localparam logic [3:0] BITS_M0 = 4'h8;
    localparam logic [3:0] BITS_M1 = 4'hA;
    localparam logic [3:0] BITS_M23 = 4'hB;
    localparam logic [3:0] RXBITS_M1 = 4'h9;
    localparam logic [3:0] RXBITS_M23 = 4'hA;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_UART8 = 2'b01,
        MODE_UART9F = 2'b10,
        MODE_UART9V = 2'b11
    } spc_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SYNC = 2'b01,
        TX_ASYNC = 2'b10
    } spc_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_ASYNC = 2'b10,
        RX_SYNC = 2'b11
    } spc_rx_st_t;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } spc_ctrl_t;

    typedef struct packed {
        spc_ctrl_t ctrl;
        logic framing_error_flag;
        logic framing_error_select;
        logic m2_double;
        logic [7:0] saddr;
        logic [7:0] smask;
        logic [15:0] baud;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        spc_tx_st_t tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_cnt;
        logic [15:0] tx_div;
        spc_rx_st_t rx_st;
        logic [9:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [15:0] rx_div;
        logic [7:0] rx_buf;
    } spc_state_t;

endpackage

// ===== hw/spc_serial_port.sv
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module spc_serial_port
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq_o,
    // Serial pins
    output logic txd,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe
);

    spc_state_t st_ff;
    spc_state_t nxt_st;
    spc_mode_t mode;
    logic req;
    logic wr;
    logic [15:0] period;
    logic [9:0] rsh;
    logic stop_bit;
    logic ninth;
    logic [7:0] rdat;

    // ====================================================
    // Helpers
    // Broadcast treats the zeros of address-or-mask as don't care
    function automatic logic addr_match(input logic [7:0] a, input logic [7:0] ind,
                                        input logic [7:0] msk);
        logic [7:0] bc;
        bc = ind | msk;
        addr_match = (((a ^ ind) & msk) == 8'h00) || (((a ^ bc) & bc) == 8'h00);
    endfunction

    function automatic logic [7:0] word_addr(input logic [7:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction

    // Mode 0 shift clock: low for the first half of each bit
    function automatic logic clk_phase(input logic [15:0] div);
        clk_phase = div < M0_HALF;
    endfunction

    // Mode 1 frames carry the stop bit where the ninth bit would be
    function automatic logic eight_bit(input spc_mode_t m);
        eight_bit = m == MODE_UART8;
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] a, input spc_state_t s);
        reg_read = 32'h0000_0000;
        case (word_addr(a))
            ADR_CTRL: begin
                reg_read[7:0] = s.ctrl;
                reg_read[7] = s.framing_error_select ? s.framing_error_flag
                                                     : s.ctrl.mode_select_hi;
            end
            ADR_DATA: reg_read[7:0] = s.rx_buf;
            ADR_PWR: begin
                reg_read[PWR_FESEL] = s.framing_error_select;
                reg_read[PWR_DBL] = s.m2_double;
            end
            ADR_SADDR: reg_read[7:0] = s.saddr;
            ADR_SMASK: reg_read[7:0] = s.smask;
            ADR_BAUD: reg_read[15:0] = s.baud;
            ADR_IRQ_ST: reg_read[2:0] = s.irq_st;
            ADR_IRQ_MASK: reg_read[2:0] = s.irq_mask;
            // Holes in the map read zero
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    assign mode = spc_mode_t'({st_ff.ctrl.mode_select_hi, st_ff.ctrl.mode_select_lo});

    // ====================================================
    // Bit period per mode
    always_comb begin
        case (mode)
            MODE_SHIFT: period = M0_PERIOD;
            MODE_UART9F: period = st_ff.m2_double ? M2_FAST : M2_SLOW;
            // Modes 1 and 3: programmed period stands in for the baud timer
            default: period = st_ff.baud;
        endcase
    end

    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where ack is sampled, while the request is still held
    assign wr = req & wb_we_i & st_ff.ack & wb_sel_i[0];

    // Frame unpacking of the receive shift register after its last shift
    assign rsh = {st_ff.rx_s2, st_ff.rx_sh[9:1]};
    assign stop_bit = rsh[9];
    assign ninth = eight_bit(mode) ? rsh[9] : rsh[8];
    assign rdat = eight_bit(mode) ? rsh[8:1] : rsh[7:0];

    // ====================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_s1 = rxd_in;
        nxt_st.rx_s2 = st_ff.rx_s1;
        nxt_st.rx_prev = st_ff.rx_s2;
        // One-cycle ack; a request still held at the ack edge is not taken again
        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack) begin
            nxt_st.dat = reg_read(wb_adr_i, st_ff);
        end

        // Software writes first; hardware events below win over clears
        if (wr) begin
            case (word_addr(wb_adr_i))
                ADR_CTRL: begin
                    nxt_st.ctrl = wb_dat_i[7:0];
                    if (st_ff.framing_error_select) begin
                        nxt_st.ctrl.mode_select_hi = st_ff.ctrl.mode_select_hi;
                        nxt_st.framing_error_flag = st_ff.framing_error_flag & wb_dat_i[7];
                    end
                    // Mode 0 reception starts on a control write with receive on, done clear
                    if (wb_dat_i[7:6] == 2'b00 && !st_ff.framing_error_select && wb_dat_i[4] &&
                        !wb_dat_i[0] && st_ff.rx_st == RX_IDLE) begin
                        nxt_st.rx_st = RX_SYNC;
                        nxt_st.rx_cnt = BITS_M0;
                        nxt_st.rx_div = M0_PERIOD - 16'h0001;
                    end
                end
                ADR_DATA: begin
                    // A write while busy is dropped; software waits for the done flag
                    if (st_ff.tx_st == TX_IDLE) begin
                        nxt_st.tx_div = period - 16'h0001;
                        if (mode == MODE_SHIFT) begin
                            nxt_st.tx_st = TX_SYNC;
                            nxt_st.tx_sh = {3'b111, wb_dat_i[7:0]};
                            nxt_st.tx_cnt = BITS_M0;
                        end else begin
                            nxt_st.tx_st = TX_ASYNC;
                            // Ninth bit only framed in modes 2 and 3
                            nxt_st.tx_sh = {1'b1, eight_bit(mode) ? 1'b1
                                            : st_ff.ctrl.tx_ninth_bit, wb_dat_i[7:0], 1'b0};
                            nxt_st.tx_cnt = eight_bit(mode) ? BITS_M1 : BITS_M23;
                        end
                    end
                end
                ADR_PWR: begin
                    nxt_st.framing_error_select = wb_dat_i[PWR_FESEL];
                    nxt_st.m2_double = wb_dat_i[PWR_DBL];
                end
                ADR_SADDR: nxt_st.saddr = wb_dat_i[7:0];
                ADR_SMASK: nxt_st.smask = wb_dat_i[7:0];
                ADR_BAUD: begin
                    if (wb_sel_i[1]) begin
                        nxt_st.baud = wb_dat_i[15:0];
                    end
                end
                ADR_IRQ_ST: nxt_st.irq_st = st_ff.irq_st & ~wb_dat_i[2:0];
                ADR_IRQ_MASK: nxt_st.irq_mask = wb_dat_i[2:0];
                default: ;
            endcase
        end

        // ================================================
        // Transmitter
        case (st_ff.tx_st)
            TX_IDLE: ;
            TX_SYNC, TX_ASYNC: begin
                if (st_ff.tx_div == 16'h0000) begin
                    nxt_st.tx_div = period - 16'h0001;
                    nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
                    nxt_st.tx_cnt = st_ff.tx_cnt - 4'h1;
                    // Async: flag as the stop bit begins; sync: after the eighth bit
                    if ((st_ff.tx_st == TX_ASYNC && st_ff.tx_cnt == 4'h2) ||
                        (st_ff.tx_st == TX_SYNC && st_ff.tx_cnt == 4'h1)) begin
                        nxt_st.ctrl.tx_done_flag = 1'b1;
                        nxt_st.irq_st[IRQ_TX] = 1'b1;
                    end
                    if (st_ff.tx_cnt == 4'h1) begin
                        nxt_st.tx_st = TX_IDLE;
                    end
                end else begin
                    nxt_st.tx_div = st_ff.tx_div - 16'h0001;
                end
            end
            default: nxt_st.tx_st = TX_IDLE;
        endcase

        // ================================================
        // Receiver
        case (st_ff.rx_st)
            RX_IDLE: begin
                if (st_ff.ctrl.rx_enable && mode != MODE_SHIFT &&
                    st_ff.rx_prev && !st_ff.rx_s2) begin
                    nxt_st.rx_st = RX_START;
                    nxt_st.rx_div = {1'b0, period[15:1]};
                end
            end
            RX_START: begin
                if (st_ff.rx_div == 16'h0000) begin
                    // A start bit gone high by mid-bit is a glitch
                    nxt_st.rx_st = st_ff.rx_s2 ? RX_IDLE : RX_ASYNC;
                    nxt_st.rx_div = period - 16'h0001;
                    nxt_st.rx_cnt = eight_bit(mode) ? RXBITS_M1 : RXBITS_M23;
                end else begin
                    nxt_st.rx_div = st_ff.rx_div - 16'h0001;
                end
            end
            RX_ASYNC: begin
                if (st_ff.rx_div == 16'h0000) begin
                    nxt_st.rx_div = period - 16'h0001;
                    nxt_st.rx_sh = rsh;
                    nxt_st.rx_cnt = st_ff.rx_cnt - 4'h1;
                    if (st_ff.rx_cnt == 4'h1) begin
                        nxt_st.rx_st = RX_IDLE;
                        // Unread frame is kept; addressed-only when multiprocessor on
                        if (!st_ff.ctrl.rx_done_flag && (!st_ff.ctrl.multiproc_enable ||
                            (ninth && addr_match(rdat, st_ff.saddr, st_ff.smask)))) begin
                            nxt_st.rx_buf = rdat;
                            nxt_st.ctrl.rx_ninth_bit = ninth;
                            nxt_st.ctrl.rx_done_flag = 1'b1;
                            nxt_st.irq_st[IRQ_RX] = 1'b1;
                        end
                        // Flagged even for a dropped frame; only software clears it
                        if (st_ff.framing_error_select && !stop_bit) begin
                            nxt_st.framing_error_flag = 1'b1;
                            nxt_st.irq_st[IRQ_FE] = 1'b1;
                        end
                    end
                end else begin
                    nxt_st.rx_div = st_ff.rx_div - 16'h0001;
                end
            end
            RX_SYNC: begin
                // Sync flops make this the pin value from late in the low phase
                if (st_ff.rx_div == M0_HALF - 16'h0001) begin
                    nxt_st.rx_sh = rsh;
                end
                if (st_ff.rx_div == 16'h0000) begin
                    nxt_st.rx_div = M0_PERIOD - 16'h0001;
                    nxt_st.rx_cnt = st_ff.rx_cnt - 4'h1;
                    if (st_ff.rx_cnt == 4'h1) begin
                        nxt_st.rx_st = RX_IDLE;
                        nxt_st.rx_buf = st_ff.rx_sh[9:2];
                        nxt_st.ctrl.rx_done_flag = 1'b1;
                        nxt_st.irq_st[IRQ_RX] = 1'b1;
                    end
                end else begin
                    nxt_st.rx_div = st_ff.rx_div - 16'h0001;
                end
            end
            default: nxt_st.rx_st = RX_IDLE;
        endcase

        // ================================================
        // Pins: in mode 0 the transmit pin carries the shift clock, low first half
        if (nxt_st.rx_st == RX_SYNC) begin
            nxt_st.txd = clk_phase(nxt_st.rx_div);
        end else if (nxt_st.tx_st == TX_SYNC) begin
            nxt_st.txd = clk_phase(nxt_st.tx_div);
        end else if (nxt_st.tx_st == TX_ASYNC) begin
            nxt_st.txd = nxt_st.tx_sh[0];
        end else begin
            nxt_st.txd = 1'b1;
        end
        nxt_st.rxd_oe = nxt_st.tx_st == TX_SYNC;
        nxt_st.rxd_out = (nxt_st.tx_st == TX_SYNC) ? nxt_st.tx_sh[0] : 1'b1;
        // Level output, registered from the next status and mask, so it changes in the same cycle as them
        nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);
    end

    // ====================================================
    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.baud <= BAUD_RST;
            st_ff.txd <= 1'b1;
            st_ff.rxd_out <= 1'b1;
            // Line idles high: no false start bit after reset
            st_ff.rx_s1 <= 1'b1;
            st_ff.rx_s2 <= 1'b1;
            st_ff.rx_prev <= 1'b1;
            st_ff.tx_st <= TX_IDLE;
            st_ff.rx_st <= RX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq_o = st_ff.irq;
    assign txd = st_ff.txd;
    assign rxd_out = st_ff.rxd_out;
    assign rxd_oe = st_ff.rxd_oe;

endmodule

// ===== tb/spc_serial_port_sva.sv
`timescale 1ns/1ns
module spc_serial_port_sva
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Interrupt and serial pins
    input wire logic irq_o,
    input wire logic txd,
    input wire logic rxd_in,
    input wire logic rxd_out,
    input wire logic rxd_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // Steps
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence mask_off;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_IRQ_MASK && wb_dat_i[2:0] == 3'h0;
    endsequence
    sequence clk_pulse;
        !txd [*6] ##1 txd;
    endsequence
    // ==========
    // Checks
    a_req_ack: assert property (bus_req |=> wb_ack_o) else $error("request not acked");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_off |-> ##[1:2] !irq_o) else $error("irq not masked");
    a_pin_idle: assert property (!rxd_oe |-> rxd_out) else $error("data pin not idle");
    a_shift_clk: assert property ($fell(txd) && rxd_oe |-> clk_pulse)
        else $error("shift clock phase wrong");
    a_shift_data: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> !txd)
        else $error("shift data moved in high phase");
endmodule

// ===== tb/spc_remote_dev.sv
`timescale 1ns/1ns
module spc_remote_dev (
    // Clock
    input wire logic sys_clk,
    // Serial lines
    input wire logic txd,
    input wire logic rxd_wire,
    output logic rxd_drv
);
    // Line has a pull-up, so released means high
    initial rxd_drv = 1'b1;
    task automatic send(input logic [10:0] fr, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            rxd_drv <= fr[i];
            repeat (p) @(posedge sys_clk);
        end
        rxd_drv <= 1'b1;
    endtask
    // Samples mid-bit; a wrong bit period garbles the frame
    task automatic cap(input int n, input int p, output logic [10:0] fr);
        fr = '0;
        wait (txd === 1'b0);
        repeat (p / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            fr[i] = txd;
            if (i < n - 1) repeat (p) @(posedge sys_clk);
        end
    endtask
    // Next bit goes out on each rising shift clock, as a shift register does
    task automatic drv0(input logic [7:0] d);
        rxd_drv <= d[0];
        for (int i = 1; i < 9; i++) begin
            @(posedge txd);
            rxd_drv <= (i < 8) ? d[i] : 1'b1;
        end
    endtask
    task automatic cap0(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            d[i] = rxd_wire;
        end
    endtask
endmodule

// ===== tb/spc_serial_port_tb.sv
`timescale 1ns/1ns
module spc_serial_port_tb;
    import spc_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, mon_m;
    logic wb_ack_o, irq_o, txd, rxd_out, rxd_oe, rxd_drv, rxd_wire;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    assign rxd_wire = rxd_oe ? rxd_out : rxd_drv;
    always #10 sys_clk = ~sys_clk;
    spc_serial_port i_spc_serial_port(.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .txd(txd), .rxd_in(rxd_wire), .rxd_out(rxd_out), .rxd_oe(rxd_oe));
    spc_remote_dev i_spc_remote_dev(.sys_clk(sys_clk), .txd(txd), .rxd_wire(rxd_wire),
        .rxd_drv(rxd_drv));
    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb_cyc(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wb_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb_cyc(1'b0, a, 32'h0000_0000);
    endtask
    // ==========
    // Read monitor
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && msk_q.size() > 0) begin
            mon_m = msk_q.pop_front();
            chk("read data", exp_q.pop_front() & mon_m, wb_dat_o & mon_m);
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        give_verdict();
    end
    // ==========
    // Main sequence
    initial begin
        logic [7:0] d, cv;
        logic [10:0] fr;
        logic n9, ok;
        int p;
        void'($urandom(65));
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        wb_rd(ADR_CTRL, 32'h0, 32'hFFFF_FFFF);
        wb_rd(ADR_BAUD, {16'h0000, BAUD_RST}, 32'hFFFF_FFFF);
        wb_rd(8'h20, 32'h0, 32'hFFFF_FFFF);
        // Bit 7 kept set so no shift-register receive starts
        d = 8'h80 | 8'($urandom());
        wb_cyc(1'b1, ADR_CTRL, {24'h0, d});
        wb_rd(ADR_CTRL, {24'h0, d}, 32'hFF);
        wb_cyc(1'b1, ADR_PWR, 32'h40);
        wb_rd(ADR_CTRL, 32'h0, 32'h80);
        wb_cyc(1'b1, ADR_BAUD, 32'h10);
        wb_cyc(1'b1, ADR_IRQ_MASK, 32'h2);
        for (int k = 0; k < 4; k++) begin
            cv = {k == 0 ? 2'b01 : k < 3 ? 2'b10 : 2'b11, 2'b00, 1'($urandom()), 3'b000};
            p = k == 1 ? 32 : k == 2 ? 64 : 16;
            wb_cyc(1'b1, ADR_PWR, k == 1 ? 32'h80 : 32'h0);
            wb_cyc(1'b1, ADR_CTRL, {24'h0, cv});
            d = 8'($urandom());
            fork
                i_spc_remote_dev.cap(k ? 11 : 10, p, fr);
                wb_cyc(1'b1, ADR_DATA, {24'h0, d});
            join
            chk("async frame", k ? {1'b1, cv[3], d, 1'b0} : {2'b01, d, 1'b0}, 32'(fr));
            wb_rd(ADR_CTRL, {24'h0, cv | 8'h02}, 32'hFF);
            chk("irq set", 32'h1, 32'(irq_o));
            wb_cyc(1'b1, ADR_IRQ_ST, 32'h2);
            @(posedge sys_clk);
            chk("irq cleared", 32'h0, 32'(irq_o));
            repeat (p) @(posedge sys_clk);
        end
        wb_cyc(1'b1, ADR_CTRL, 32'h0);
        d = 8'($urandom());
        fork
            i_spc_remote_dev.cap0(fr[7:0]);
            wb_cyc(1'b1, ADR_DATA, {24'h0, d});
        join
        chk("shift byte", {24'h0, d}, {24'h0, fr[7:0]});
        repeat (12) @(posedge sys_clk);
        wb_rd(ADR_CTRL, 32'h02, 32'hFF);
        // Mode 0 reception: device clocks, partner shifts a byte in
        d = 8'($urandom());
        fork
            i_spc_remote_dev.drv0(d);
            wb_cyc(1'b1, ADR_CTRL, 32'h10);
        join
        repeat (12) @(posedge sys_clk);
        wb_rd(ADR_CTRL, 32'h11, 32'hFF);
        wb_rd(ADR_DATA, {24'h0, d}, 32'hFF);
        wb_cyc(1'b1, ADR_SADDR, 32'h5A);
        wb_cyc(1'b1, ADR_SMASK, 32'hFF);
        // Mode 1, mode 3, disabled, then address filtering cases
        for (int k = 0; k < 6; k++) begin
            cv = k == 0 ? 8'h50 : k == 1 ? 8'hD0 : k == 2 ? 8'hC0 : 8'hF0;
            n9 = k == 1 ? 1'($urandom()) : k > 3;
            d = k > 2 ? (k == 4 ? 8'h33 : 8'h5A) : 8'($urandom());
            ok = k < 2 || k == 5;
            wb_cyc(1'b1, ADR_CTRL, {24'h0, cv});
            i_spc_remote_dev.send(k ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0}, k ? 11 : 10, 16);
            repeat (4) @(posedge sys_clk);
            wb_rd(ADR_CTRL, {24'h0, cv | {5'h0, ok && (k ? n9 : 1'b1), 1'b0, ok}},
                ok ? 32'h07 : 32'h03);
            if (ok) wb_rd(ADR_DATA, {24'h0, d}, 32'hFF);
        end
        // Framing error: bad stop bit sets the flag in bit 7, a written zero clears it
        wb_cyc(1'b1, ADR_PWR, 32'h40);
        wb_cyc(1'b1, ADR_IRQ_MASK, 32'h4);
        wb_cyc(1'b1, ADR_CTRL, 32'h50);
        d = 8'($urandom());
        i_spc_remote_dev.send({1'b0, 1'b1, d, 1'b0}, 11, 16);
        repeat (4) @(posedge sys_clk);
        wb_rd(ADR_CTRL, 32'h85, 32'h85);
        chk("fe irq", 32'h1, 32'(irq_o));
        wb_cyc(1'b1, ADR_CTRL, 32'h50);
        wb_rd(ADR_CTRL, 32'h40, 32'hC0);
        wb_cyc(1'b1, ADR_IRQ_MASK, 32'h0);
        give_verdict();
    end
endmodule
bind spc_serial_port spc_serial_port_sva i_spc_serial_port_sva(.sys_clk(sys_clk),
    .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe));
